//--- gpiopm_pkg.sv
// package for the gpio port pad, interrupt and mux block
package gpiopm_pkg;
  localparam int PIN_COUNT = 8;
  localparam int FUNC_SEL_W = 4;
  localparam int TRIG_W = 3;

  // drive strength encodings
  localparam logic [1:0] DRIVE_LOW = 2'h0;
  localparam logic [1:0] DRIVE_MEDIUM = 2'h1;
  localparam logic [1:0] DRIVE_HIGH = 2'h2;
  localparam logic [1:0] DRIVE_HIGH_SLEW_CTL = 2'h3;

  // pad type encodings
  localparam logic [2:0] PAD_PUSH_PULL = 3'h0;
  localparam logic [2:0] PAD_PUSH_PULL_PULLUP = 3'h1;
  localparam logic [2:0] PAD_PUSH_PULL_PULLDOWN = 3'h2;
  localparam logic [2:0] PAD_OPEN_DRAIN = 3'h3;
  localparam logic [2:0] PAD_OPEN_DRAIN_PULLUP = 3'h4;
  localparam logic [2:0] PAD_OPEN_DRAIN_PULLDOWN = 3'h5;
  localparam logic [2:0] PAD_ANALOG = 3'h6;

  // trigger encodings
  localparam logic [2:0] TRIG_FALLING = 3'h0;
  localparam logic [2:0] TRIG_RISING = 3'h1;
  localparam logic [2:0] TRIG_BOTH = 3'h2;
  localparam logic [2:0] TRIG_LOW = 3'h3;
  localparam logic [2:0] TRIG_HIGH = 3'h4;

  // reset values
  localparam logic [1:0] DRIVE_RESET = DRIVE_LOW;
  localparam logic [2:0] PAD_RESET = PAD_PUSH_PULL;
  localparam logic [3:0] FUNC_RESET = 4'h0;
  localparam logic [2:0] TRIG_RESET = TRIG_FALLING;

  // stored pad configuration of one pin
  typedef struct packed {
    logic [1:0] drive_strength_sel;
    logic [2:0] pad_type_sel;
  } gpiopm_pad_t;

  // electrical controls delivered to one pad
  typedef struct packed {
    logic pull_up;
    logic pull_down;
    logic analog_en;
    logic open_drain;
    logic slew_ctl;
    logic [1:0] drive;
  } gpiopm_padctl_t;
endpackage : gpiopm_pkg

//--- gpiopm_port.sv
// eight-pin gpio port: pad config, function mux, pin interrupts
// ****************************************
// ****************************************
module gpiopm_port
  import gpiopm_pkg::*;
#(
  parameter int PINS = PIN_COUNT,
  parameter int FSEL_W = FUNC_SEL_W,
  parameter int FUNCS = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // access selection
  input wire logic [PINS-1:0] pin_select_mask,
  input wire logic [2:0] pin_index,
  // pad configuration write and readback
  input wire logic pad_cfg_wr,
  input wire logic [1:0] drive_strength_sel,
  input wire logic [2:0] pad_type_sel,
  output logic [1:0] drive_strength_rd,
  output logic [2:0] pad_type_rd,
  // trigger configuration
  input wire logic trig_cfg_wr,
  input wire logic [TRIG_W-1:0] trig_sel,
  // function mux
  input wire logic func_cfg_wr,
  input wire logic [FSEL_W-1:0] pin_function_sel,
  input wire logic [PINS-1:0] dir_out,
  input wire logic [PINS-1:0] sw_out,
  input wire logic [FUNCS-1:0] periph_out,
  input wire logic [FUNCS-1:0] periph_oe,
  output logic [FUNCS-1:0] periph_in,
  // interrupt control and status
  input wire logic int_enable_wr,
  input wire logic int_disable_wr,
  input wire logic int_clear_wr,
  input wire logic status_view_masked,
  output logic [PINS-1:0] int_status,
  output logic [PINS-1:0] int_raw,
  output logic [PINS-1:0] int_masked,
  output logic port_irq,
  // pin reads
  output logic [PINS-1:0] pin_value_rd,
  // pins and pad controls
  input wire logic [PINS-1:0] pin_in,
  output logic [PINS-1:0] pin_out,
  output logic [PINS-1:0] pin_oe_b,
  output gpiopm_padctl_t [PINS-1:0] pad_ctl
);

  // ****************************************
  // configuration storage
  // ****************************************
  gpiopm_pad_t [PINS-1:0] pad_cfg;
  logic [PINS-1:0][FSEL_W-1:0] func_sel;
  logic [PINS-1:0][TRIG_W-1:0] trig_cfg;
  logic [PINS-1:0] int_en;
  logic [PINS-1:0] raw;
  logic [PINS-1:0] pin_prev;
  logic [PINS-1:0] detect;
  logic [PINS-1:0] drive_en;
  logic [PINS-1:0] drive_val;
  logic [PINS-1:0] next_raw;
  logic [PINS-1:0] next_en;

  function automatic logic is_pull_up(input logic [2:0] t);
    return t == PAD_PUSH_PULL_PULLUP || t == PAD_OPEN_DRAIN_PULLUP;
  endfunction : is_pull_up

  function automatic logic is_pull_down(input logic [2:0] t);
    return t == PAD_PUSH_PULL_PULLDOWN || t == PAD_OPEN_DRAIN_PULLDOWN;
  endfunction : is_pull_down

  function automatic logic is_open_drain(input logic [2:0] t);
    return t == PAD_OPEN_DRAIN || t == PAD_OPEN_DRAIN_PULLUP ||
           t == PAD_OPEN_DRAIN_PULLDOWN;
  endfunction : is_open_drain

  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi++) begin : g_pin
      // selected pins take pad and trigger writes at once; function writes go to the pin named by pin_index
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          pad_cfg[gi] <= '{DRIVE_RESET, PAD_RESET};
          func_sel[gi] <= FSEL_W'(FUNC_RESET);
          trig_cfg[gi] <= TRIG_RESET;
        end else begin
          if (pad_cfg_wr && pin_select_mask[gi]) begin
            pad_cfg[gi] <= '{drive_strength_sel, pad_type_sel};
          end
          if (func_cfg_wr && pin_index == 3'(gi)) begin
            func_sel[gi] <= pin_function_sel;
          end
          if (trig_cfg_wr && pin_select_mask[gi]) begin
            trig_cfg[gi] <= trig_sel;
          end
        end
      end

      // stored pad and trigger settings follow every selected write
      cfg_store_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        (pad_cfg_wr && pin_select_mask[gi]) |=>
          pad_cfg[gi] == $past({drive_strength_sel, pad_type_sel}))
        else $error("pad setting not stored");

      trig_store_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        (trig_cfg_wr && pin_select_mask[gi]) |=>
          trig_cfg[gi] == $past(trig_sel))
        else $error("trigger setting not stored");

      // open drain, slew and drive settings reach the pad only when dir_out is set; pulls act regardless of direction
      wire logic is_analog = pad_cfg[gi].pad_type_sel == PAD_ANALOG;
      wire logic od = is_open_drain(pad_cfg[gi].pad_type_sel);
      assign pad_ctl[gi].pull_up = is_pull_up(pad_cfg[gi].pad_type_sel);
      assign pad_ctl[gi].pull_down = is_pull_down(pad_cfg[gi].pad_type_sel);
      assign pad_ctl[gi].analog_en = is_analog;
      assign pad_ctl[gi].open_drain = od & dir_out[gi];
      assign pad_ctl[gi].slew_ctl = dir_out[gi] &
        (pad_cfg[gi].drive_strength_sel == DRIVE_HIGH_SLEW_CTL);
      assign pad_ctl[gi].drive = dir_out[gi] ?
        pad_cfg[gi].drive_strength_sel : DRIVE_LOW;

      // function zero is plain gpio; one function per pin by construction
      wire logic use_fn = func_sel[gi] != '0;
      assign drive_en[gi] = ~is_analog & (use_fn ?
        periph_oe[func_sel[gi]] : dir_out[gi]);
      assign drive_val[gi] = use_fn ? periph_out[func_sel[gi]] : sw_out[gi];
      // open drain never drives high, only releases
      assign pin_oe_b[gi] = ~(drive_en[gi] & ~(od & drive_val[gi]));
      assign pin_out[gi] = od ? 1'b0 : drive_val[gi];

      // an analog pad or a released open drain leaves the pin alone
      analog_off_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        is_analog |-> pin_oe_b[gi])
        else $error("analog pad drives pin");

      od_high_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        (od && drive_val[gi]) |-> pin_oe_b[gi])
        else $error("open drain drove high");

      input_quiet_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        (!dir_out[gi] && !use_fn) |-> (pin_oe_b[gi] &&
          !pad_ctl[gi].slew_ctl && pad_ctl[gi].drive == DRIVE_LOW))
        else $error("input pin shows output pad setting");

      fn_route_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        (use_fn && !od && !is_analog && periph_oe[func_sel[gi]]) |->
          (!pin_oe_b[gi] && pin_out[gi] == periph_out[func_sel[gi]]))
        else $error("routed function not on pin");

      // trigger detection: edges against the previous sampled level, levels from the current one
      always_comb begin
        case (trig_cfg[gi])
          TRIG_FALLING: detect[gi] = pin_prev[gi] & ~pin_in[gi];
          TRIG_RISING: detect[gi] = ~pin_prev[gi] & pin_in[gi];
          TRIG_BOTH: detect[gi] = pin_prev[gi] ^ pin_in[gi];
          TRIG_LOW: detect[gi] = ~pin_in[gi];
          TRIG_HIGH: detect[gi] = pin_in[gi];
          default: detect[gi] = 1'b0;
        endcase
      end
    end
  endgenerate

  // peripheral inputs see the pin routed to them; last pin wins if two
  // pins carry the same function, which software must avoid
  always_comb begin
    periph_in = '0;
    for (int p = 0; p < PINS; p++) begin
      if (func_sel[p] != '0) begin
        periph_in[func_sel[p]] = pin_in[p];
      end
    end
  end

  // ****************************************
  // interrupt state
  // ****************************************
  // a new event wins over a clear in the same cycle
  assign next_raw = (raw & ~(int_clear_wr ? pin_select_mask : '0))
                    | detect;
  assign next_en = int_enable_wr ? (int_en | pin_select_mask) :
                   int_disable_wr ? (int_en & ~pin_select_mask) :
                   int_en;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      raw <= '0;
      int_en <= '0;
      pin_prev <= '0;
    end else begin
      raw <= next_raw;
      int_en <= next_en;
      pin_prev <= pin_in;
    end
  end

  assign int_raw = raw;
  assign int_masked = raw & int_en;
  assign port_irq = |int_masked;
  assign int_status = status_view_masked ? int_masked : int_raw;

  // ****************************************
  // read paths
  // ****************************************
  // pin level is taken from the pad input for both directions
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pin_value_rd <= '0;
      drive_strength_rd <= DRIVE_RESET;
      pad_type_rd <= PAD_RESET;
    end else begin
      pin_value_rd <= pin_in & pin_select_mask;
      drive_strength_rd <= pad_cfg[pin_index].drive_strength_sel;
      pad_type_rd <= pad_cfg[pin_index].pad_type_sel;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  // reads carry the mask and pin level of the cycle before
  read_mask_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    (pin_value_rd & ~$past(pin_select_mask)) == '0)
    else $error("unselected pin read nonzero");

  read_level_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    $past(rst_b) |->
      pin_value_rd == ($past(pin_in) & $past(pin_select_mask)))
    else $error("pin read mismatch");

  // a disabled pin drops out of the masked view at once
  masked_drop_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    (int_disable_wr && !int_enable_wr) |=>
      (int_masked & $past(pin_select_mask)) == '0)
    else $error("disabled pin left in masked status");

  irq_event_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    ((detect & int_en) != '0 && !int_disable_wr) |=> port_irq)
    else $error("enabled event raised no irq");

  enable_set_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    int_enable_wr |=> ((int_en & $past(pin_select_mask)) ==
      $past(pin_select_mask)) && ((int_en & ~$past(pin_select_mask)) ==
      ($past(int_en) & ~$past(pin_select_mask))))
    else $error("enable write wrong");

  disable_clr_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    (int_disable_wr && !int_enable_wr) |=>
      (int_en & $past(pin_select_mask)) == '0)
    else $error("disable write wrong");

  // events keep landing during a clear, so other pins may gain bits
  clear_keep_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    int_clear_wr |=> (int_raw & ~$past(pin_select_mask)) ==
      (($past(int_raw) | $past(detect)) & ~$past(pin_select_mask)))
    else $error("clear disturbed other pins");

  status_view_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    status_view_masked |-> (int_status & ~int_en) == '0)
    else $error("masked view shows disabled pin");

  pad_read_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    (pad_cfg_wr && pin_select_mask[pin_index]) ##1
      (!pad_cfg_wr && pin_index == $past(pin_index)) |=>
      drive_strength_rd == $past(drive_strength_sel, 2))
    else $error("pad readback wrong");

  cov_irq_c: cover property (@(posedge clk) disable iff (!rst_b)
    !port_irq ##1 port_irq);
  cov_clear_c: cover property (@(posedge clk) disable iff (!rst_b)
    port_irq && int_clear_wr ##1 !port_irq);
  cov_func_c: cover property (@(posedge clk) disable iff (!rst_b)
    func_cfg_wr && pin_function_sel != '0);
  cov_read_c: cover property (@(posedge clk) disable iff (!rst_b)
    pin_value_rd != '0);
  cov_view_c: cover property (@(posedge clk) disable iff (!rst_b)
    status_view_masked && int_status != '0);

endmodule : gpiopm_port

//--- gpiopm_board.sv
// board-side model of the lines attached to the eight port pins
module gpiopm_board
  import gpiopm_pkg::*;
(
  // clock
  input wire logic clk,
  // pad side of the port
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe_b,
  input wire gpiopm_padctl_t [7:0] pad_ctl,
  // board drivers set by the bench
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  output logic [7:0] pin_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] float_pat = 8'h55;
  // a floating line wanders, so it never keeps its last level
  always @(posedge clk) float_pat <= ~float_pat;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!pin_oe_b[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (pad_ctl[i].pull_up) pin_in[i] = 1'b1;
      else if (pad_ctl[i].pull_down) pin_in[i] = 1'b0;
      else pin_in[i] = float_pat[i];
    end
  end
endmodule : gpiopm_board

//--- gpiopm_port_test.sv
// self-checking bench for the gpio port pad, interrupt and mux block
module gpiopm_port_test
  import gpiopm_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PAD = 0, TRG = 1, FNC = 2, ENA = 3, DIS = 4, CLR = 5;
  localparam int NONE = 6;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] mask = 8'h00;
  logic [2:0] idx = 3'h0;
  logic [4:0] val = 5'h00;
  logic [6:0] stb = 7'h00;
  logic view_m = 1'b0;
  logic [7:0] dir_out = 8'h00;
  logic [7:0] sw_out = 8'h00;
  logic [7:0] ext_val = 8'hA5;
  logic [7:0] ext_en = 8'h0F;
  logic [15:0] p_out = 16'h0000;
  logic [15:0] p_oe = 16'h0000;
  logic [15:0] periph_in;
  logic [1:0] drive_rd;
  logic [2:0] pad_rd;
  logic [7:0] int_status, int_raw, int_masked, pin_value_rd;
  logic [7:0] pin_in, pin_out, pin_oe_b;
  logic port_irq;
  gpiopm_padctl_t [7:0] pad_ctl;
  int error_cnt = 0;
  int samples_checked = 0;
  int cycles = 0;

  gpiopm_port gpiopm_port_i (
    .clk(clk), .rst_b(rst_b), .pin_select_mask(mask), .pin_index(idx),
    .pad_cfg_wr(stb[0]), .drive_strength_sel(val[4:3]),
    .pad_type_sel(val[2:0]), .drive_strength_rd(drive_rd),
    .pad_type_rd(pad_rd), .trig_cfg_wr(stb[1]), .trig_sel(val[2:0]),
    .func_cfg_wr(stb[2]), .pin_function_sel(val[3:0]), .dir_out(dir_out),
    .sw_out(sw_out), .periph_out(p_out), .periph_oe(p_oe),
    .periph_in(periph_in), .int_enable_wr(stb[3]),
    .int_disable_wr(stb[4]), .int_clear_wr(stb[5]),
    .status_view_masked(view_m), .int_status(int_status),
    .int_raw(int_raw), .int_masked(int_masked), .port_irq(port_irq),
    .pin_value_rd(pin_value_rd), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_b(pin_oe_b), .pad_ctl(pad_ctl));
  gpiopm_board gpiopm_board_i (.clk(clk), .pin_out(pin_out),
    .pin_oe_b(pin_oe_b), .pad_ctl(pad_ctl), .ext_val(ext_val),
    .ext_en(ext_en), .pin_in(pin_in));

  always #12.5 clk = ~clk;

  // ****************************************
  // access tasks
  // ****************************************
  // NONE only moves mask and index, as a read does
  task pulse(input int k, input logic [7:0] m, input logic [2:0] i,
             input logic [4:0] v);
    @(posedge clk);
    mask <= m;
    idx <= i;
    val <= v;
    stb[k] <= 1'b1;
    @(posedge clk);
    stb[k] <= 1'b0;
  endtask : pulse
  task drive_ext(input logic [7:0] e);
    @(posedge clk);
    ext_val <= e;
  endtask : drive_ext
  task look(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : look
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  // hang guard: the tests need about 120 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    look(1);
    chk("drive_rd", 8'(drive_rd), 8'h00);
    chk("int_raw", int_raw, 8'h00);
    // upper nibble driven by the port, lower nibble by the board
    @(posedge clk);
    dir_out <= 8'hF0;
    sw_out <= 8'h90;
    pulse(NONE, 8'hFF, 3'h0, 5'h00);
    look(2);
    chk("pin_value_rd", pin_value_rd, 8'h95);
    pulse(NONE, 8'h3C, 3'h0, 5'h00);
    look(2);
    chk("pin_value_rd", pin_value_rd, 8'h14);
    $display("test pin reads done");
    pulse(NONE, 8'h00, 3'h0, 5'h00);
    dir_out <= 8'h00;
    ext_en <= 8'hFF;
    ext_val <= 8'h00;
    for (int k = 0; k < 5; k++) pulse(TRG, 8'(1 << k), 3'h0, 5'(k));
    drive_ext(8'hFF);
    look(3);
    pulse(CLR, 8'h1F, 3'h0, 5'h00);
    look(2);
    // pins 6 and 5 still hold events from the earlier read test, pin 7 fell when dir_out was cleared
    chk("int_raw", int_raw, 8'hF0);
    drive_ext(8'h00);
    look(3);
    chk("int_raw", int_raw, 8'hFD);
    pulse(CLR, 8'hFF, 3'h0, 5'h00);
    look(2);
    chk("int_raw", int_raw, 8'h08);
    drive_ext(8'hFF);
    look(3);
    chk("int_raw", int_raw, 8'h1E);
    pulse(ENA, 8'h06, 3'h0, 5'h00);
    look(1);
    chk("int_masked", int_masked, 8'h06);
    chk("port_irq", 8'(port_irq), 8'h01);
    chk("int_status", int_status, 8'h1E);
    pulse(DIS, 8'h02, 3'h0, 5'h00);
    view_m <= 1'b1;
    look(1);
    chk("int_status", int_status, 8'h04);
    pulse(CLR, 8'h04, 3'h0, 5'h00);
    look(2);
    chk("int_raw", int_raw, 8'h1A);
    chk("port_irq", 8'(port_irq), 8'h00);
    $display("test interrupts done");
    pulse(FNC, 8'h00, 3'h3, 5'h05);
    pulse(FNC, 8'h00, 3'h7, 5'h02);
    drive_ext(8'h08);
    look(2);
    chk("periph_in", 8'(periph_in[5]), 8'h01);
    chk("periph_in", 8'(periph_in[2]), 8'h00);
    $display("test function mux done");
    for (int k = 0; k < 7; k++) pulse(PAD, 8'(1 << k), 3'h0, {2'(k), 3'(k)});
    for (int k = 0; k < 8; k++) begin
      pulse(NONE, 8'h00, 3'(k), 5'h00);
      look(1);
      chk("drive_rd", 8'(drive_rd), (k < 7) ? 8'(k % 4) : 8'h00);
      chk("pad_rd", 8'(pad_rd), (k < 7) ? 8'(k) : 8'h00);
    end
    chk("pull_up", 8'(pad_ctl[1].pull_up), 8'h01);
    chk("pull_down", 8'(pad_ctl[2].pull_down), 8'h01);
    chk("drive", 8'(pad_ctl[3].drive), 8'h00);
    chk("analog_en", 8'(pad_ctl[6].analog_en), 8'h01);
    $display("test pad config done");
    // pin 3 driven low by function 5, pin 7 high by function 2
    @(posedge clk);
    dir_out <= 8'hFF;
    sw_out <= 8'h30;
    p_oe <= 16'h0024;
    p_out <= 16'h0004;
    pulse(NONE, 8'hFF, 3'h0, 5'h00);
    look(2);
    chk("pin_oe_b", pin_oe_b, 8'h70);
    chk("pin_out", pin_out, 8'h80);
    chk("pin_value_rd", pin_value_rd, 8'h80);
    chk("slew_ctl", 8'(pad_ctl[3].slew_ctl), 8'h01);
    chk("open_drain", 8'(pad_ctl[3].open_drain), 8'h01);
    chk("drive", 8'(pad_ctl[2].drive), 8'h02);
    $display("test pin drive done");
    tally_and_finish();
  end
endmodule : gpiopm_port_test
